// [shared/vector_map_pkg.sv]
package vector_map_pkg;

    // ==========================================================
    // Widths and counts
    // ==========================================================
    localparam int ADDR_W = 24;
    localparam int N_FIXED = 6;
    localparam int N_MASK = 36;
    localparam int FIX_IW = 3;
    localparam int MASK_IW = 6;

    // ==========================================================
    // Priority levels
    // ==========================================================
    localparam logic [1:0] LEVEL_FIXED = 2'h3;
    // A maskable source programmed to 3 is switched off
    localparam logic [1:0] LEVEL_OFF = 2'h3;
    localparam logic [1:0] LEVEL_RST = 2'h0;

    // ==========================================================
    // Level 3 sources, highest first
    // ==========================================================
    localparam logic [FIX_IW-1:0] FIX_HW_RESET = 3'h0;
    localparam logic [FIX_IW-1:0] FIX_STACK_ERR = 3'h1;
    localparam logic [FIX_IW-1:0] FIX_ILLEGAL = 3'h2;
    localparam logic [FIX_IW-1:0] FIX_DEBUG = 3'h3;
    localparam logic [FIX_IW-1:0] FIX_TRAP = 3'h4;
    localparam logic [FIX_IW-1:0] FIX_NMI = 3'h5;

    localparam logic [7:0] FIX_OFS [N_FIXED] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A};

    // ==========================================================
    // Maskable sources, index is priority order within a level, 0 highest
    // ==========================================================
    localparam logic [MASK_IW-1:0] SRC_EXT_A = 6'h00;
    localparam logic [MASK_IW-1:0] SRC_DMA0 = 6'h04;
    localparam logic [MASK_IW-1:0] SRC_HOST_CMD = 6'h0A;
    localparam logic [MASK_IW-1:0] SRC_SSP0_RX_EXC = 6'h0D;
    localparam logic [MASK_IW-1:0] SRC_SSP1_RX_EXC = 6'h13;
    localparam logic [MASK_IW-1:0] SRC_ASP_RX_EXC = 6'h19;
    localparam logic [MASK_IW-1:0] SRC_TMR0_OVF = 6'h1E;

    // Offsets per source, listed in priority order within a level.
    // Unassigned slots $0C,$0E,$3C,$3E,$4C,$4E,$5A-$5E,$66-$FE have no entry.
    localparam logic [7:0] MASK_OFS [N_MASK] = '{
        8'h10, 8'h12, 8'h14, 8'h16,
        8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
        // Host command, tx empty, rx full
        8'h64, 8'h62, 8'h60,
        8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36,
        8'h42, 8'h40, 8'h44, 8'h48, 8'h4A, 8'h46,
        // Async port rx exc, rx, tx, idle, timer
        8'h52, 8'h50, 8'h54, 8'h56, 8'h58,
        8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E, 8'h2C
    };

    // ==========================================================
    // Offer sequencer
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OFFER = 3'b010,
        ST_RETIRE = 3'b100
    } offer_state_e;

    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [MASK_IW-1:0] SRC_RST = 6'h00;

endpackage : vector_map_pkg

// [src/interrupt_vector_map.sv]
`timescale 1ns/1ps

// Overview of operation
// - Six fixed sources at $00-$0A, level 3
// - Maskable levels 0-2; lines, DMA, timers mapped
// - First sync port rx exception $32, rx $30
// - First sync port tx exception $38, tx $36
// - First sync port rx last slot $34
// - First sync port tx last slot $3A
// - Second sync port rx exception $42, rx $40
// - Second sync port tx exception $48, tx $46
// - Second sync port rx last slot $44
// - Second sync port tx last slot $4A
// - Async port slots $50-$58, rest unassigned
// - Host receive full at $60
// - Host tx empty $62, command $64
// - Same level: lines A-D, then DMA 0-5
module interrupt_vector_map
    import vector_map_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] vector_base,
    input wire logic [1:0] core_mask_level,
    input wire logic [N_FIXED-1:0] fixed_req,
    input wire logic [N_MASK-1:0] mask_req,
    input wire logic [1:0] priority_level [N_MASK],
    input wire logic vector_taken,
    output logic vector_valid_r,
    output logic [ADDR_W-1:0] vector_addr_r,
    output logic [1:0] vector_level_r,
    output logic vector_fixed_r,
    output logic [MASK_IW-1:0] vector_src_r
);

    // ==========================================================
    // Level qualification
    // ==========================================================
    logic [N_MASK-1:0] at_lvl2;
    logic [N_MASK-1:0] at_lvl1;
    logic [N_MASK-1:0] at_lvl0;
    logic [N_MASK-1:0] cand;
    logic [1:0] cand_level;

    genvar g;
    generate
        for (g = 0; g < N_MASK; g++) begin : g_qual
            assign at_lvl2[g] = mask_req[g] && priority_level[g] == 2'h2
                && core_mask_level <= 2'h2;
            assign at_lvl1[g] = mask_req[g] && priority_level[g] == 2'h1
                && core_mask_level <= 2'h1;
            assign at_lvl0[g] = mask_req[g] && priority_level[g] == 2'h0
                && core_mask_level == 2'h0;
        end
    endgenerate

    // Highest pending level wins before order within a level
    always_comb begin
        if (|at_lvl2) begin
            cand = at_lvl2;
            cand_level = 2'h2;
        end else if (|at_lvl1) begin
            cand = at_lvl1;
            cand_level = 2'h1;
        end else begin
            cand = at_lvl0;
            cand_level = 2'h0;
        end
    end

    // ==========================================================
    // Source choice
    // ==========================================================
    logic fix_found;
    logic [FIX_IW-1:0] fix_idx;
    logic mask_found;
    logic [MASK_IW-1:0] mask_idx;

    vector_first_pick #(
        .N(N_FIXED),
        .IW(FIX_IW)
    ) u_fix_pick (
        .req(fixed_req),
        .found(fix_found),
        .idx(fix_idx)
    );

    vector_first_pick #(
        .N(N_MASK),
        .IW(MASK_IW)
    ) u_mask_pick (
        .req(cand),
        .found(mask_found),
        .idx(mask_idx)
    );

    // ==========================================================
    // Offer sequencer
    // ==========================================================
    offer_state_e state_r;
    offer_state_e state_nxt;
    logic valid_nxt;
    logic [ADDR_W-1:0] addr_nxt;
    logic [1:0] level_nxt;
    logic fixed_nxt;
    logic [MASK_IW-1:0] src_nxt;

    always_comb begin
        state_nxt = state_r;
        valid_nxt = vector_valid_r;
        addr_nxt = vector_addr_r;
        level_nxt = vector_level_r;
        fixed_nxt = vector_fixed_r;
        src_nxt = vector_src_r;
        case (state_r)
            ST_IDLE: begin
                if (fix_found) begin
                    state_nxt = ST_OFFER;
                    valid_nxt = 1'b1;
                    addr_nxt = vector_base + {16'h0000, FIX_OFS[fix_idx]};
                    level_nxt = LEVEL_FIXED;
                    fixed_nxt = 1'b1;
                    src_nxt = MASK_IW'(fix_idx);
                end else if (mask_found) begin
                    state_nxt = ST_OFFER;
                    valid_nxt = 1'b1;
                    addr_nxt = vector_base + {16'h0000, MASK_OFS[mask_idx]};
                    level_nxt = cand_level;
                    fixed_nxt = 1'b0;
                    src_nxt = mask_idx;
                end
            end
            ST_OFFER: begin
                // Held stable until the core fetch takes it
                if (vector_taken) begin
                    state_nxt = ST_RETIRE;
                    valid_nxt = 1'b0;
                end
            end
            ST_RETIRE: begin
                // One idle cycle lets the source drop its request
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
                valid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            vector_valid_r <= 1'b0;
            vector_addr_r <= ADDR_RST;
            vector_level_r <= LEVEL_RST;
            vector_fixed_r <= 1'b0;
            vector_src_r <= SRC_RST;
        end else begin
            state_r <= state_nxt;
            vector_valid_r <= valid_nxt;
            vector_addr_r <= addr_nxt;
            vector_level_r <= level_nxt;
            vector_fixed_r <= fixed_nxt;
            vector_src_r <= src_nxt;
        end
    end

endmodule : interrupt_vector_map

// [src/vector_first_pick.sv]
`timescale 1ns/1ps

// ==========================================================
// Lowest set index wins
// ==========================================================
module vector_first_pick #(
    parameter int N = 8,
    parameter int IW = 3
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [IW-1:0] idx
);

    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = IW'(i);
            end
        end
    end

endmodule : vector_first_pick

// [verif/core_fetch_model.sv]
`timescale 1ns/1ps

// ====
// Core fetch, takes an offer after wait_n cycles
// ====
module core_fetch_model (
    input logic mclk,
    input logic rst,
    input logic vector_valid_r,
    input logic [3:0] wait_n,
    output logic vector_taken
);
    logic [3:0] cnt_r;
    // One-cycle pulse; the offer is gone by the next falling edge
    always @(negedge mclk or posedge rst) begin
        if (rst) begin
            vector_taken <= 1'b0;
            cnt_r <= 4'h0;
        end else if (vector_taken) begin
            vector_taken <= 1'b0;
            cnt_r <= 4'h0;
        end else if (vector_valid_r) begin
            vector_taken <= (cnt_r >= wait_n);
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule : core_fetch_model

// [verif/interrupt_vector_map_props.sv]
`timescale 1ns/1ps

// ====
// Offer checks
// ====
module vector_map_checker
    import vector_map_pkg::*;
(
    input logic mclk,
    input logic rst,
    input logic [ADDR_W-1:0] vector_base,
    input logic [1:0] core_mask_level,
    input logic [N_FIXED-1:0] fixed_req,
    input logic vector_taken,
    input logic vector_valid_r,
    input logic [ADDR_W-1:0] vector_addr_r,
    input logic [1:0] vector_level_r,
    input logic vector_fixed_r,
    input logic [MASK_IW-1:0] vector_src_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Requests as the sequencer sampled them
    logic [N_FIXED-1:0] fix_q;
    always_ff @(posedge mclk) begin
        fix_q <= fixed_req;
    end
    property p_fix_lvl; vector_valid_r && vector_fixed_r |-> vector_level_r == 2'h3; endproperty
    a_fix_lvl: assert property (p_fix_lvl) else $error("fixed level");
    property p_fix_addr; $rose(vector_valid_r) && vector_fixed_r
        |-> vector_addr_r == $past(vector_base) + 24'(FIX_OFS[vector_src_r]); endproperty
    a_fix_addr: assert property (p_fix_addr) else $error("fixed addr");
    property p_fix_first; $rose(vector_valid_r) && vector_fixed_r |-> fix_q[vector_src_r]
        && (fix_q & ((6'h1 << vector_src_r) - 6'h1)) == 6'h0; endproperty
    a_fix_first: assert property (p_fix_first) else $error("fixed order");
    property p_beats; $rose(vector_valid_r) |-> vector_fixed_r == (fix_q != 6'h0); endproperty
    a_beats: assert property (p_beats) else $error("fixed must win");
    property p_msk_addr; $rose(vector_valid_r) && !vector_fixed_r
        |-> vector_addr_r == $past(vector_base) + 24'(MASK_OFS[vector_src_r]); endproperty
    a_msk_addr: assert property (p_msk_addr) else $error("mask addr");
    property p_mask_ok; $rose(vector_valid_r) && !vector_fixed_r
        |-> vector_level_r >= $past(core_mask_level) && vector_level_r != 2'h3; endproperty
    a_mask_ok: assert property (p_mask_ok) else $error("masked offer");
    property p_retire; vector_valid_r && vector_taken |=> !vector_valid_r [*2]; endproperty
    a_retire: assert property (p_retire) else $error("retire");
    property p_stand; vector_valid_r && !vector_taken
        |=> vector_valid_r && $stable(vector_addr_r) && $stable(vector_src_r); endproperty
    a_stand: assert property (p_stand) else $error("offer moved");
    c_fixed: cover property ($rose(vector_valid_r) && vector_fixed_r);
    c_mask: cover property ($rose(vector_valid_r) && !vector_fixed_r);
    c_slow: cover property (vector_valid_r && !vector_taken ##1 vector_taken);
endmodule : vector_map_checker

bind interrupt_vector_map vector_map_checker chk (.mclk(mclk), .rst(rst),
    .vector_base(vector_base), .core_mask_level(core_mask_level), .fixed_req(fixed_req),
    .vector_taken(vector_taken), .vector_valid_r(vector_valid_r),
    .vector_addr_r(vector_addr_r), .vector_level_r(vector_level_r),
    .vector_fixed_r(vector_fixed_r), .vector_src_r(vector_src_r));

// [verif/tb_top.sv]
`timescale 1ns/1ps

module tb_top
    import vector_map_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] vector_base = 24'h12FFF0;
    logic [1:0] core_mask_level = 2'h0;
    logic [N_FIXED-1:0] fixed_req = 6'h0;
    logic [N_MASK-1:0] mask_req = 36'h0;
    logic [1:0] prio [N_MASK];
    logic vector_taken, vector_valid_r, vector_fixed_r;
    logic [ADDR_W-1:0] vector_addr_r;
    logic [1:0] vector_level_r;
    logic [MASK_IW-1:0] vector_src_r;
    logic [3:0] wait_n = 4'h3;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    interrupt_vector_map dut (.mclk(mclk), .rst(rst), .vector_base(vector_base),
        .core_mask_level(core_mask_level), .fixed_req(fixed_req), .mask_req(mask_req),
        .priority_level(prio), .vector_taken(vector_taken), .vector_valid_r(vector_valid_r),
        .vector_addr_r(vector_addr_r), .vector_level_r(vector_level_r),
        .vector_fixed_r(vector_fixed_r), .vector_src_r(vector_src_r));
    core_fetch_model core (.mclk(mclk), .rst(rst), .vector_valid_r(vector_valid_r),
        .wait_n(wait_n), .vector_taken(vector_taken));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // ====
    // Offer handling
    // ====
    task automatic take(input logic [23:0] a, input logic [1:0] l, input logic f, input int s);
        int n;
        n = 0;
        while (vector_valid_r !== 1'b1 && n < 9) begin
            @(negedge mclk);
            n++;
        end
        // An offer that never came must not pass on stale fields
        check("valid", 24'(vector_valid_r), 24'h1);
        check("addr", vector_addr_r, a);
        check("level", 24'(vector_level_r), 24'(l));
        check("fixed", 24'(vector_fixed_r), 24'(f));
        check("src", 24'(vector_src_r), 24'(s));
        n = 0;
        while (vector_valid_r !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
        end
    endtask : take
    task automatic s_fixed();
        mask_req = '1;
        for (int i = 0; i < 6; i++) begin
            fixed_req = 6'h3F << i;
            take(vector_base + 24'(2 * i), 2'h3, 1'b1, i);
        end
        fixed_req = 6'h0;
        mask_req = '0;
    endtask : s_fixed
    task automatic s_table();
        logic [7:0] ofs [36];
        logic [23:0] exp_a;
        ofs = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22, 8'h64,
            8'h62, 8'h60, 8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36, 8'h42, 8'h40, 8'h44, 8'h48,
            8'h4A, 8'h46, 8'h52, 8'h50, 8'h54, 8'h56, 8'h58, 8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E,
            8'h2C};
        wait_n = 4'h0;
        foreach (prio[i]) prio[i] = 2'(i % 3);
        for (int i = 0; i < 36; i++) begin
            mask_req = 36'h1 << i;
            exp_a = vector_base + 24'(ofs[i]);
            if (i < 13)
                take(exp_a, prio[i], 1'b0, i);
            else if (i < 19)
                take(exp_a, prio[i], 1'b0, i);
            else if (i < 25)
                take(exp_a, prio[i], 1'b0, i);
            else
                take(exp_a, prio[i], 1'b0, i);
        end
        mask_req = '0;
    endtask : s_table
    task automatic s_order();
        // Base near the top so the add wraps
        vector_base = 24'hFFFFF0;
        wait_n = 4'h1;
        foreach (prio[i]) prio[i] = 2'h1;
        prio[5] = 2'h2;
        prio[20] = 2'h2;
        mask_req = '1;
        take(24'h00000A, 2'h2, 1'b0, 5);
        mask_req[5] = 1'b0;
        take(24'h000030, 2'h2, 1'b0, 20);
        mask_req[20] = 1'b0;
        core_mask_level = 2'h2;
        repeat (4) @(negedge mclk);
        check("masked", 24'(vector_valid_r), 24'h0);
        core_mask_level = 2'h1;
        prio[0] = 2'h3;
        take(24'h000002, 2'h1, 1'b0, 1);
        mask_req = '0;
    endtask : s_order
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        foreach (prio[i]) prio[i] = 2'h1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        s_fixed();
        s_table();
        s_order();
        close_out();
    end
endmodule : tb_top
